// ==== logic/tps_pkg.sv ====
// Shared constants and carriers for the timer, shared prescaler and
// interrupt control block.
// Assumes a single core clock and an 8-bit register port on the CPU side.
package tps_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TPS_ADDR_COUNT  = 8'h01;
    localparam logic [7:0] TPS_ADDR_IRQ    = 8'h0B;
    localparam logic [7:0] TPS_ADDR_OPTION = 8'h81;

    // ------------------------------------------------------------------
    // Field positions of timer_option_config
    // ------------------------------------------------------------------
    localparam int TPS_OPT_RATE_LSB = 0;
    localparam int TPS_OPT_RATE_W   = 3;
    localparam int TPS_OPT_ASSIGN   = 3;
    localparam int TPS_OPT_EDGE     = 4;
    localparam int TPS_OPT_SOURCE   = 5;

    // ------------------------------------------------------------------
    // Field positions of irq_control
    // ------------------------------------------------------------------
    localparam int TPS_IRQ_GLOBAL_EN = 7;
    localparam int TPS_IRQ_PERIPH_EN = 6;
    localparam int TPS_IRQ_T0IE  = 5;
    localparam int TPS_IRQ_INTE  = 4;
    localparam int TPS_IRQ_RBIE  = 3;
    localparam int TPS_IRQ_T0IF  = 2;
    localparam int TPS_IRQ_INTF  = 1;
    localparam int TPS_IRQ_RBIF  = 0;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] TPS_OPTION_RST = 8'hFF;
    localparam logic [7:0] TPS_IRQ_RST    = 8'h00;
    localparam logic [7:0] TPS_COUNT_RST  = 8'h00;
    localparam int         TPS_CORE_HZ    = 25_000_000;
    localparam int         TPS_INSTR_DIV  = 4;
    localparam int         TPS_PRE_W      = 8;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tps_bus_req_t;

    typedef struct packed {
        logic rb_change;
        logic ext_int;
        logic periph_irq;
    } tps_events_t;

endpackage

// ==== logic/tps_prescaler.sv ====
// Shared binary prescaler: divides input ticks by 2**shift.
// Assumes in_tick is a one-cycle pulse in the core clock domain.
`timescale 1ns/100ps
module tps_prescaler
#(
    parameter int PRE_W = tps_pkg::TPS_PRE_W
)
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      clear,
    input  wire logic                      in_tick,
    input  wire logic [$clog2(PRE_W+1)-1:0] shift,
    output logic                           out_tick
);
    import tps_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
    } tps_pre_state_t;

    tps_pre_state_t s_r;
    tps_pre_state_t s_nxt;
    logic [PRE_W-1:0] mask;

    if (PRE_W < 1) begin : g_chk
        $error("tps_prescaler: PRE_W must be at least 1");
    end

    always_comb
    begin
        mask     = PRE_W'(({{PRE_W{1'b0}}, 1'b1} << shift) - 1'b1);
        out_tick = in_tick && ((s_r.cnt & mask) == mask);
        s_nxt    = s_r;
        if (clear)
        begin
            s_nxt.cnt = '0;
        end
        else if (in_tick)
        begin
            s_nxt.cnt = PRE_W'(s_r.cnt + 1'b1);
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // After a pass the low bits wrap to zero, so the next pass needs 2**shift ticks
    a_prescale_wrap: assert property (@(posedge core_clk) disable iff (rst)
        (out_tick && !clear) |=> ((s_r.cnt & $past(mask)) == '0))
        else $error("prescaler did not wrap after a pass");

endmodule // tps_prescaler

// ==== logic/tps_timer_ctrl.sv ====
// Top of the 8-bit timer with its clock source selection, edge select,
// shared timer/watchdog prescaler and interrupt control register.
// Assumes all pins are synchronous to core_clk and that the watchdog
// oscillator delivers one-cycle ticks on wdt_osc_tick.
`timescale 1ns/100ps
module tps_timer_ctrl
#(
    parameter int INSTR_DIV = tps_pkg::TPS_INSTR_DIV
)
(
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire tps_pkg::tps_bus_req_t bus,
    input  wire tps_pkg::tps_events_t  ev,
    input  wire logic               timer_ext_clock_pin,
    input  wire logic               wdt_osc_tick,
    output logic [7:0]              rd_data,
    output logic                    irq_req,
    output logic                    wdt_tick_out,
    output logic                    instr_clock_out
);
    import tps_pkg::*;

    localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV - 1);
    localparam int SH_W = $clog2(TPS_PRE_W + 1);

    if (INSTR_DIV < 2) begin : g_chk
        $error("tps_timer_ctrl: INSTR_DIV must be at least 2");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]       option;
        logic [7:0]       irqc;
        logic [7:0]       count;
        logic [7:0]       rdata;
        logic [DIV_W-1:0] div;
        logic             pin_prev;
        logic             irq;
        logic             wdt_out;
        logic             iclk;
    } tps_state_t;

    tps_state_t s_r;
    tps_state_t s_nxt;

    logic            instr_tick;
    logic            pin_edge;
    logic            src_tick;
    logic            pre_in;
    logic            pre_out;
    logic            pre_clear;
    logic [SH_W-1:0] pre_shift;
    logic            cnt_tick;
    logic            overflow;
    logic            wr_count;
    logic            wr_irq;
    logic            wr_option;
    logic            to_wdt;
    logic [2:0]      rate;

    // ------------------------------------------------------------------
    // Shared prescaler
    // ------------------------------------------------------------------
    tps_prescaler #(
        .PRE_W    (TPS_PRE_W)
    ) u_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (pre_clear),
        .in_tick  (pre_in),
        .shift    (pre_shift),
        .out_tick (pre_out)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt     = s_r;
        wr_count  = bus.wr && (bus.addr == TPS_ADDR_COUNT);
        wr_irq    = bus.wr && (bus.addr == TPS_ADDR_IRQ);
        wr_option = bus.wr && (bus.addr == TPS_ADDR_OPTION);
        to_wdt    = s_r.option[TPS_OPT_ASSIGN];
        rate      = s_r.option[TPS_OPT_RATE_LSB +: TPS_OPT_RATE_W];

        // Instruction cycle enable from the core clock divider
        instr_tick = (s_r.div == DIV_LAST);
        s_nxt.div  = instr_tick ? '0 : DIV_W'(s_r.div + 1'b1);
        s_nxt.iclk = (s_nxt.div < DIV_W'(INSTR_DIV / 2)) ? 1'b0 : 1'b1;

        // Pin edge, polarity chosen by the edge select
        s_nxt.pin_prev = timer_ext_clock_pin;
        if (s_r.option[TPS_OPT_EDGE])
        begin
            pin_edge = s_r.pin_prev && !timer_ext_clock_pin;
        end
        else
        begin
            pin_edge = !s_r.pin_prev && timer_ext_clock_pin;
        end
        src_tick = s_r.option[TPS_OPT_SOURCE] ? pin_edge : instr_tick;

        // Prescaler goes to one user only; the other gets its ticks undivided
        pre_in    = to_wdt ? wdt_osc_tick : src_tick;
        pre_shift = to_wdt ? SH_W'(rate) : SH_W'(rate) + 1'b1;
        cnt_tick  = to_wdt ? src_tick : pre_out;
        s_nxt.wdt_out = to_wdt ? pre_out : wdt_osc_tick;
        // Reassigning the prescaler or rewriting the count restarts it,
        // so a stale partial count never leaks into the new user
        pre_clear = wr_count || wr_option;

        // Timer count
        overflow = 1'b0;
        if (wr_count)
        begin
            s_nxt.count = bus.wdata;
        end
        else if (cnt_tick)
        begin
            s_nxt.count = 8'(s_r.count + 1'b1);
            overflow    = (s_r.count == 8'hFF);
        end

        if (wr_option)
        begin
            s_nxt.option = bus.wdata;
        end

        // Interrupt control: events set flags regardless of enables,
        // and an event in the cycle of a software clear wins
        if (wr_irq)
        begin
            s_nxt.irqc = bus.wdata;
        end
        if (overflow)
        begin
            s_nxt.irqc[TPS_IRQ_T0IF] = 1'b1;
        end
        if (ev.ext_int)
        begin
            s_nxt.irqc[TPS_IRQ_INTF] = 1'b1;
        end
        if (ev.rb_change)
        begin
            s_nxt.irqc[TPS_IRQ_RBIF] = 1'b1;
        end

        s_nxt.irq = s_r.irqc[TPS_IRQ_GLOBAL_EN] && (
            (s_r.irqc[TPS_IRQ_T0IE] && s_r.irqc[TPS_IRQ_T0IF]) ||
            (s_r.irqc[TPS_IRQ_INTE] && s_r.irqc[TPS_IRQ_INTF]) ||
            (s_r.irqc[TPS_IRQ_RBIE] && s_r.irqc[TPS_IRQ_RBIF]) ||
            (s_r.irqc[TPS_IRQ_PERIPH_EN] && ev.periph_irq));

        // Read data stand for one cycle only; unmapped reads give zero
        s_nxt.rdata = 8'h00;
        if (bus.rd)
        begin
            unique case (bus.addr)
                TPS_ADDR_COUNT:  s_nxt.rdata = s_r.count;
                TPS_ADDR_IRQ:    s_nxt.rdata = s_r.irqc;
                TPS_ADDR_OPTION: s_nxt.rdata = s_r.option;
                default:         s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r          <= '0;
            s_r.option   <= TPS_OPTION_RST;
            s_r.irqc     <= TPS_IRQ_RST;
            s_r.count    <= TPS_COUNT_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rd_data         = s_r.rdata;
    assign irq_req         = s_r.irq;
    assign wdt_tick_out    = s_r.wdt_out;
    assign instr_clock_out = s_r.iclk;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_internal_count: assert property (
        (!s_r.option[TPS_OPT_SOURCE] && s_r.option[TPS_OPT_ASSIGN] && instr_tick && !bus.wr)
        |=> (s_r.count == 8'($past(s_r.count) + 1'b1)))
        else $error("timer missed an instruction cycle tick");

    a_internal_hold: assert property (
        (!s_r.option[TPS_OPT_SOURCE] && s_r.option[TPS_OPT_ASSIGN] && !instr_tick && !bus.wr)
        |=> $stable(s_r.count))
        else $error("timer moved without an instruction cycle tick");

    a_rising_edge: assert property (
        (s_r.option[TPS_OPT_SOURCE] && !s_r.option[TPS_OPT_EDGE] && s_r.option[TPS_OPT_ASSIGN]
         && !s_r.pin_prev && timer_ext_clock_pin && !bus.wr)
        |=> (s_r.count == 8'($past(s_r.count) + 1'b1)))
        else $error("rising pin edge not counted");

    a_falling_edge: assert property (
        (s_r.option[TPS_OPT_SOURCE] && s_r.option[TPS_OPT_EDGE] && s_r.option[TPS_OPT_ASSIGN]
         && s_r.pin_prev && !timer_ext_clock_pin && !bus.wr)
        |=> (s_r.count == 8'($past(s_r.count) + 1'b1)))
        else $error("falling pin edge not counted");

    a_wdt_bypass: assert property (
        (!s_r.option[TPS_OPT_ASSIGN] && !bus.wr) |=> (s_r.wdt_out == $past(wdt_osc_tick)))
        else $error("watchdog tick not passed through while prescaler is on the timer");

    a_timer_divided: assert property (
        (!s_r.option[TPS_OPT_ASSIGN] && cnt_tick && !bus.wr) ##1
        (!s_r.option[TPS_OPT_ASSIGN] && !bus.wr) |-> !cnt_tick)
        else $error("timer counted two ticks in a row through the prescaler");

    a_overflow_flag: assert property (
        (cnt_tick && !wr_count && (s_r.count == 8'hFF))
        |=> (s_r.irqc[TPS_IRQ_T0IF] && (s_r.count == 8'h00)))
        else $error("overflow did not set its flag");

    a_event_flags: assert property (
        (ev.rb_change && ev.ext_int)
        |=> (s_r.irqc[TPS_IRQ_RBIF] && s_r.irqc[TPS_IRQ_INTF]))
        else $error("external or port change event lost");

    a_irq_readback: assert property (
        (wr_irq && !ev.rb_change && !ev.ext_int && !overflow) ##1
        (!bus.wr && !ev.rb_change && !ev.ext_int && !overflow) ##1
        (bus.rd && bus.addr == TPS_ADDR_IRQ)
        |=> (rd_data == $past(bus.wdata, 3)))
        else $error("interrupt control did not read back as written");

    a_periph_block: assert property (
        (!s_r.irqc[TPS_IRQ_PERIPH_EN] && !(s_r.irqc[TPS_IRQ_T0IE] && s_r.irqc[TPS_IRQ_T0IF])
         && !(s_r.irqc[TPS_IRQ_INTE] && s_r.irqc[TPS_IRQ_INTF])
         && !(s_r.irqc[TPS_IRQ_RBIE] && s_r.irqc[TPS_IRQ_RBIF]))
        |=> !irq_req)
        else $error("peripheral interrupt passed while blocked");

    a_periph_pass: assert property (
        (s_r.irqc[TPS_IRQ_GLOBAL_EN] && s_r.irqc[TPS_IRQ_PERIPH_EN] && ev.periph_irq)
        |=> irq_req)
        else $error("enabled peripheral interrupt not raised");

    a_read_pulse: assert property (
        !bus.rd |=> (rd_data == 8'h00))
        else $error("read data held beyond its cycle");

endmodule // tps_timer_ctrl

// ==== test/tps_cpu_model.sv ====
// CPU-side register master for the timer and interrupt control block.
// Assumes the slave answers a read in the cycle after the strobe and never stalls.
`timescale 1ns/100ps
module tps_cpu_model
(
    input  wire logic             core_clk,
    input  wire logic [7:0]       rd_data,
    output tps_pkg::tps_bus_req_t bus
);
    import tps_pkg::*;

    initial bus = '0;

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    end
    endtask

    // Data are taken mid-cycle while they stand, clear of the edge that launches them
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
    begin
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        d = rd_data;
    end
    endtask

    // Port B direction bit 3 under low-voltage programming is software's duty,
    // on a register outside this block; this master never touches it
    // Stale flags go first so an old event cannot fire the moment enables land
    task automatic irq_enable(input logic [7:0] en);
    begin
        wr(TPS_ADDR_IRQ, 8'h00);
        wr(TPS_ADDR_IRQ, en & 8'hF8);
    end
    endtask
endmodule // tps_cpu_model

// ==== test/tps_timer_ctrl_tb_top.sv ====
// Self-checking bench for the timer, shared prescaler and interrupt control.
// Assumes tps_cpu_model drives the register port; events and pins come from here.
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tps_timer_ctrl_tb_top;
    import tps_pkg::*;

    typedef struct {logic [7:0] opt; int gap; logic [7:0] dt; int dw;} tps_row_t;

    logic         core_clk    = 1'b0;
    logic         rst         = 1'b1;
    tps_bus_req_t bus;
    tps_events_t  ev          = '0;
    logic         pin         = 1'b0;
    logic         osc         = 1'b0;
    logic [2:0]   ph          = 3'h0;
    logic [7:0]   rd_data;
    logic         irq_req;
    logic         wdt_tick_out;
    logic [7:0]   a;
    logic [7:0]   b;
    int           error_cnt   = 0;
    int           check_count = 0;
    int           wdt_cnt     = 0;
    int           ticks_left  = 0;
    int           w0;
    tps_row_t     rows[16];

    always #20 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Watchdog oscillator ticks, one every 8 cycles, and output counting
    // ------------------------------------------------------------------
    // Output pulses are counted mid-cycle, away from the edge that launches them
    always @(negedge core_clk)
    begin
        if (wdt_tick_out === 1'b1)
            wdt_cnt++;
    end

    always @(posedge core_clk)
    begin
        ph <= ph + 3'h1;
        osc <= (ticks_left > 0) && (ph == 3'h0);
        if ((ticks_left > 0) && (ph == 3'h0))
            ticks_left--;
    end

    tps_cpu_model i_tps_cpu_model (.core_clk(core_clk), .rd_data(rd_data), .bus(bus));

    tps_timer_ctrl #(.INSTR_DIV(4)) i_tps_timer_ctrl
    (
        .core_clk(core_clk), .rst(rst), .bus(bus), .ev(ev), .timer_ext_clock_pin(pin),
        .wdt_osc_tick(osc), .rd_data(rd_data), .irq_req(irq_req),
        .wdt_tick_out(wdt_tick_out), .instr_clock_out()
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        i_tps_cpu_model.wr(ad, d);
    endtask

    task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] v;
        i_tps_cpu_model.rd(ad, v);
        `CHK(v, exp)
    endtask

    task test_done;
    begin
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    initial
    begin
        #2_000_000;
        error_cnt++;
        test_done;
    end

    initial
    begin
        // Timer rows divide by 2^(r+1); watchdog rows divide ticks by 2^r, timer 1:1
        for (int i = 0; i < 8; i++)
        begin
            rows[i] = '{8'(i), 32 << (i + 1), 8'd8, -1};
            rows[i + 8] = '{8'h08 | 8'(i), 520, 8'd130, 64 >> i};
        end
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(TPS_ADDR_OPTION, TPS_OPTION_RST);
        rdc(TPS_ADDR_IRQ, 8'h00);
        rdc(TPS_ADDR_COUNT, 8'h00);
        wr(TPS_ADDR_OPTION, 8'hC8);
        wr(8'h77, 8'h55);
        rdc(TPS_ADDR_OPTION, 8'hC8);
        rdc(8'h77, 8'h00);
        wr(TPS_ADDR_IRQ, 8'h78);
        rdc(TPS_ADDR_IRQ, 8'h78);
        // --------------------------------------------------------------
        // Rate table; the window is the distance between read strobes
        // --------------------------------------------------------------
        foreach (rows[i])
        begin
            wr(TPS_ADDR_OPTION, rows[i].opt);
            @(negedge core_clk);
            w0 = wdt_cnt;
            ticks_left = 64;
            i_tps_cpu_model.rd(TPS_ADDR_COUNT, a);
            cyc(rows[i].gap - 2);
            i_tps_cpu_model.rd(TPS_ADDR_COUNT, b);
            cyc(4);
            `CHK(8'(b - a), rows[i].dt)
            if (rows[i].dw >= 0)
                `CHK(wdt_cnt - w0, rows[i].dw)
        end
        // --------------------------------------------------------------
        // Pin source and edge select
        // --------------------------------------------------------------
        wr(TPS_ADDR_OPTION, 8'h38);
        i_tps_cpu_model.rd(TPS_ADDR_COUNT, a);
        @(posedge core_clk) pin <= 1'b1;
        cyc(4);
        rdc(TPS_ADDR_COUNT, a);
        @(posedge core_clk) pin <= 1'b0;
        cyc(4);
        rdc(TPS_ADDR_COUNT, 8'(a + 1));
        wr(TPS_ADDR_OPTION, 8'h28);
        @(posedge core_clk) pin <= 1'b1;
        cyc(4);
        rdc(TPS_ADDR_COUNT, 8'(a + 2));
        @(posedge core_clk) pin <= 1'b0;
        cyc(4);
        rdc(TPS_ADDR_COUNT, 8'(a + 2));
        // --------------------------------------------------------------
        // Flags set with all enables off, overflow included
        // --------------------------------------------------------------
        wr(TPS_ADDR_COUNT, 8'hFF);
        wr(TPS_ADDR_IRQ, 8'h00);
        @(posedge core_clk);
        pin <= 1'b1;
        ev <= '{rb_change: 1'b1, ext_int: 1'b1, periph_irq: 1'b0};
        @(posedge core_clk) ev <= '0;
        cyc(4);
        rdc(TPS_ADDR_IRQ, 8'h07);
        `CHK(irq_req, 1'b0)
        i_tps_cpu_model.irq_enable(8'h90);
        cyc(2);
        @(negedge core_clk);
        `CHK(irq_req, 1'b0)
        @(posedge core_clk) ev.ext_int <= 1'b1;
        @(posedge core_clk) ev.ext_int <= 1'b0;
        @(negedge core_clk);
        `CHK(irq_req, 1'b0)
        @(negedge core_clk);
        `CHK(irq_req, 1'b1)
        // --------------------------------------------------------------
        // Peripheral gate, then a reset in mid-run
        // --------------------------------------------------------------
        wr(TPS_ADDR_IRQ, 8'h80);
        @(posedge core_clk) ev.periph_irq <= 1'b1;
        cyc(4);
        @(negedge core_clk);
        `CHK(irq_req, 1'b0)
        wr(TPS_ADDR_IRQ, 8'hC0);
        cyc(2);
        @(negedge core_clk);
        `CHK(irq_req, 1'b1)
        rst <= 1'b1;
        @(negedge core_clk);
        `CHK(irq_req, 1'b0)
        @(posedge core_clk) rst <= 1'b0;
        ev.periph_irq <= 1'b0;
        rdc(TPS_ADDR_OPTION, TPS_OPTION_RST);
        rdc(TPS_ADDR_IRQ, 8'h00);
        test_done;
    end
endmodule // tps_timer_ctrl_tb_top
